// *** rtl/serial_port_regs.vh ***
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_FIFO 3'h2
`define OFS_LINE_FMT 3'h3
`define OFS_HS_OUT 3'h4
`define OFS_LINE_FLAGS 3'h5
`define OFS_HS_IN 3'h6
`define OFS_SCRATCH 3'h7
`define BIT_DIV_ACCESS 7
`define DIV_RESET 16'h000c
`define TICKS_PER_BIT 5'h10
`define REF_CLOCK_HZ 1843200
`define SYS_CLOCK_HZ 100000000
`define FIFO_DEPTH 16
`endif

// *** rtl/fifo_async_serial_port.v ***
`include "serial_port_regs.vh"
module fifo_async_serial_port #(
    parameter [9:0] BASE_WIDTH = 10'h000
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst_b,
    // host bus
    input wire [9:0] i_addr,
    input wire [9:0] i_base_switch,
    input wire i_rd,
    input wire i_wr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output wire o_irq,
    // serial line and handshake
    input wire i_rx,
    output reg o_tx,
    input wire i_cts,
    input wire i_dsr,
    input wire i_ri,
    input wire i_dcd,
    output wire o_dtr,
    output wire o_rts
);
    reg rst_s1_q, rst_b_q;
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_b_q <= rst_s1_q;
        end
    end

    // address decode: offset from switch base
    wire sel = (i_addr[9:3] == i_base_switch[9:3]);
    wire [2:0] ofs = i_addr[2:0];
    wire wr = i_wr && sel;
    wire rd = i_rd && sel;

    reg [7:0] div_lo_q, div_hi_q, ier_q, line_format_reg_q, handshake_output_reg_q, scr_q;
    reg [1:0] trig_q;
    reg fifo_en_q;
    wire divisor_access_select = line_format_reg_q[`BIT_DIV_ACCESS];
    wire [15:0] divisor = {div_hi_q, div_lo_q};

    // reference tick generator: 1.8432 MHz from 100 MHz by phase accumulator
    reg [26:0] acc_q;
    reg ref_tick_q;
    wire [27:0] acc_sum = {1'b0, acc_q} + 28'd`REF_CLOCK_HZ;
    // baud tick: ref / divisor = 16x bit rate
    reg [15:0] bdiv_q;
    reg tick16_q;
    always @(posedge i_clock or negedge rst_b_q) begin
        if (!rst_b_q) begin
            acc_q <= 27'h0;
            ref_tick_q <= 1'b0;
            bdiv_q <= 16'h0;
            tick16_q <= 1'b0;
        end else begin
            if (acc_sum >= 28'd`SYS_CLOCK_HZ) begin
                acc_q <= acc_sum[26:0] - 27'd`SYS_CLOCK_HZ;
                ref_tick_q <= 1'b1;
            end else begin
                acc_q <= acc_sum[26:0];
                ref_tick_q <= 1'b0;
            end
            tick16_q <= 1'b0;
            if (ref_tick_q) begin
                if (bdiv_q + 16'h1 >= divisor) begin
                    bdiv_q <= 16'h0;
                    tick16_q <= 1'b1;
                end else begin
                    bdiv_q <= bdiv_q + 16'h1;
                end
            end
        end
    end

    // character geometry
    wire [3:0] nbits = 4'h5 + {2'b00, line_format_reg_q[1:0]};
    wire par_en = line_format_reg_q[3];
    wire par_even = line_format_reg_q[4];
    wire par_stick = line_format_reg_q[5];

    // fifos: 8 data bits plus 3 error bits in receive
    reg [7:0] tx_mem [0:`FIFO_DEPTH-1];
    reg [10:0] rx_mem [0:`FIFO_DEPTH-1];
    reg [3:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    reg [4:0] tx_cnt_q, rx_cnt_q;
    wire [4:0] tx_cap = fifo_en_q ? 5'd16 : 5'd1;
    wire [4:0] rx_cap = fifo_en_q ? 5'd16 : 5'd1;
    wire [10:0] rx_head = rx_mem[rx_rp_q];

    // transmit engine
    localparam TX_IDLE = 2'd0, TX_START = 2'd1, TX_DATA = 2'd2, TX_STOP = 2'd3;
    reg [1:0] tx_st_q;
    reg [3:0] tx_sub_q, tx_idx_q;
    reg [7:0] tx_sh_q;
    reg tx_par_q;
    // launch only on a baud tick so the start bit lasts a full sixteen ticks
    wire tx_pop = (tx_st_q == TX_IDLE) && (tx_cnt_q != 5'd0) && tx_sub_q == 4'h0 &&
        tick16_q;
    wire tx_bit_end = tick16_q && (tx_sub_q == 4'hf);
    wire [3:0] data_len = nbits + (par_en ? 4'h1 : 4'h0);
    wire [3:0] stop_last = (line_format_reg_q[2] ? 4'h1 : 4'h0);
    reg tx_line;
    always @* begin
        case (tx_st_q)
            TX_START: tx_line = 1'b0;
            TX_DATA: tx_line = (tx_idx_q == nbits) ?
                (par_stick ? ~par_even : (par_even ? tx_par_q : ~tx_par_q)) : tx_sh_q[0];
            default: tx_line = 1'b1;
        endcase
    end
    always @(posedge i_clock or negedge rst_b_q) begin
        if (!rst_b_q) begin
            tx_st_q <= TX_IDLE;
            tx_sub_q <= 4'h0;
            tx_idx_q <= 4'h0;
            tx_sh_q <= 8'h0;
            tx_par_q <= 1'b0;
            o_tx <= 1'b1;
        end else begin
            o_tx <= line_format_reg_q[6] ? 1'b0 : tx_line;
            if (tx_pop) begin
                tx_st_q <= TX_START;
                tx_sh_q <= tx_mem[tx_rp_q];
                tx_par_q <= 1'b0;
                tx_sub_q <= 4'h0;
            end else if (tick16_q && tx_st_q != TX_IDLE) begin
                tx_sub_q <= tx_sub_q + 4'h1;
                if (tx_bit_end) begin
                    case (tx_st_q)
                        TX_START: begin
                            tx_st_q <= TX_DATA;
                            tx_idx_q <= 4'h0;
                        end
                        TX_DATA: begin
                            if (tx_idx_q < nbits) begin
                                tx_par_q <= tx_par_q ^ tx_sh_q[0];
                                tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                            end
                            if (tx_idx_q + 4'h1 == data_len) begin
                                tx_st_q <= TX_STOP;
                                tx_idx_q <= 4'h0;
                            end else begin
                                tx_idx_q <= tx_idx_q + 4'h1;
                            end
                        end
                        TX_STOP: begin
                            if (tx_idx_q == stop_last) tx_st_q <= TX_IDLE;
                            else tx_idx_q <= tx_idx_q + 4'h1;
                        end
                        default: tx_st_q <= TX_IDLE;
                    endcase
                end
            end
        end
    end

    // receive engine, mid-bit sampling with 16 ticks per bit
    localparam RX_IDLE = 2'd0, RX_START = 2'd1, RX_DATA = 2'd2, RX_STOP = 2'd3;
    reg [1:0] rx_st_q;
    reg [3:0] rx_sub_q, rx_idx_q;
    reg [7:0] rx_sh_q;
    reg rx_par_q, rx_perr_q, rx_brk_q, rx_push_q;
    reg [10:0] rx_word_q;
    wire rx_mid = tick16_q && rx_sub_q == 4'h7;
    always @(posedge i_clock or negedge rst_b_q) begin
        if (!rst_b_q) begin
            rx_st_q <= RX_IDLE;
            rx_sub_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 8'h0;
            rx_par_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_brk_q <= 1'b0;
            rx_push_q <= 1'b0;
            rx_word_q <= 11'h0;
        end else begin
            rx_push_q <= 1'b0;
            if (rx_st_q == RX_IDLE) begin
                rx_sub_q <= 4'h0;
                if (tick16_q && !i_rx) rx_st_q <= RX_START;
            end else if (tick16_q) begin
                rx_sub_q <= rx_sub_q + 4'h1;
                if (rx_mid) begin
                    case (rx_st_q)
                        RX_START: begin
                            rx_st_q <= i_rx ? RX_IDLE : RX_DATA;
                            rx_idx_q <= 4'h0;
                            rx_par_q <= 1'b0;
                            rx_brk_q <= 1'b1;
                            rx_sh_q <= 8'h0;
                        end
                        RX_DATA: begin
                            rx_brk_q <= rx_brk_q & ~i_rx;
                            if (rx_idx_q < nbits) begin
                                rx_sh_q[rx_idx_q[2:0]] <= i_rx;
                                rx_par_q <= rx_par_q ^ i_rx;
                            end else begin
                                rx_perr_q <= par_stick ? (i_rx != ~par_even) :
                                    ((rx_par_q ^ i_rx) != ~par_even);
                            end
                            if (rx_idx_q + 4'h1 == data_len) rx_st_q <= RX_STOP;
                            rx_idx_q <= rx_idx_q + 4'h1;
                            if (rx_idx_q == 4'h0) rx_perr_q <= 1'b0;
                        end
                        RX_STOP: begin
                            rx_st_q <= RX_IDLE;
                            rx_push_q <= 1'b1;
                            // {break, framing, parity, data}
                            rx_word_q <= {rx_brk_q & ~i_rx, ~i_rx, rx_perr_q & par_en,
                                rx_sh_q};
                        end
                        default: rx_st_q <= RX_IDLE;
                    endcase
                end
            end
        end
    end

    // host-side fifo control and registers
    wire tx_wr = wr && ofs == `OFS_DATA && !divisor_access_select;
    wire rx_rd = rd && ofs == `OFS_DATA && !divisor_access_select;
    wire fifo_control_wr = wr && ofs == `OFS_FIFO;
    wire rx_clr = fifo_control_wr && i_wdata[1];
    wire tx_clr = fifo_control_wr && i_wdata[2];
    wire rx_pop = rx_rd && rx_cnt_q != 5'd0;
    wire rx_full = rx_cnt_q >= rx_cap;
    reg overrun_q, brk_flag_q, fe_flag_q, pe_flag_q;
    reg [`FIFO_DEPTH-1:0] err_map_q;
    reg [3:0] hs_prev_q, delta_q;
    wire line_condition_rd = rd && ofs == `OFS_LINE_FLAGS;
    wire handshake_input_rd = rd && ofs == `OFS_HS_IN;
    wire [3:0] hs_now = {i_dcd, i_ri, i_dsr, i_cts};
    wire [3:0] hs_evt = {hs_prev_q[3] ^ i_dcd, hs_prev_q[2] & ~i_ri,
        hs_prev_q[1] ^ i_dsr, hs_prev_q[0] ^ i_cts};
    always @(posedge i_clock or negedge rst_b_q) begin
        if (!rst_b_q) begin
            {div_hi_q, div_lo_q} <= `DIV_RESET;
            ier_q <= 8'h00;
            line_format_reg_q <= 8'h03;
            handshake_output_reg_q <= 8'h00;
            scr_q <= 8'h00;
            trig_q <= 2'b00;
            fifo_en_q <= 1'b0;
            tx_wp_q <= 4'h0;
            tx_rp_q <= 4'h0;
            tx_cnt_q <= 5'd0;
            rx_wp_q <= 4'h0;
            rx_rp_q <= 4'h0;
            rx_cnt_q <= 5'd0;
            overrun_q <= 1'b0;
            brk_flag_q <= 1'b0;
            fe_flag_q <= 1'b0;
            pe_flag_q <= 1'b0;
            err_map_q <= {`FIFO_DEPTH{1'b0}};
            hs_prev_q <= 4'h0;
            delta_q <= 4'h0;
        end else begin
            if (wr) begin
                case (ofs)
                    `OFS_DATA: if (divisor_access_select) div_lo_q <= i_wdata;
                    `OFS_IER: if (divisor_access_select) div_hi_q <= i_wdata;
                        else ier_q <= {4'h0, i_wdata[3:0]};
                    `OFS_FIFO: begin
                        fifo_en_q <= i_wdata[0];
                        trig_q <= i_wdata[7:6];
                    end
                    `OFS_LINE_FMT: line_format_reg_q <= i_wdata;
                    `OFS_HS_OUT: handshake_output_reg_q <= {6'h0, i_wdata[1:0]};
                    `OFS_SCRATCH: scr_q <= i_wdata;
                    default: ;
                endcase
            end
            // transmit fifo
            if (tx_clr) begin
                tx_wp_q <= 4'h0;
                tx_rp_q <= 4'h0;
                tx_cnt_q <= 5'd0;
            end else begin
                if (tx_wr && tx_cnt_q < tx_cap) begin
                    tx_mem[tx_wp_q] <= i_wdata;
                    tx_wp_q <= tx_wp_q + 4'h1;
                end
                if (tx_pop) tx_rp_q <= tx_rp_q + 4'h1;
                tx_cnt_q <= tx_cnt_q + ((tx_wr && tx_cnt_q < tx_cap) ? 5'd1 : 5'd0)
                    - (tx_pop ? 5'd1 : 5'd0);
            end
            // receive fifo; a full fifo drops the new byte and flags overrun
            if (rx_clr) begin
                rx_wp_q <= 4'h0;
                rx_rp_q <= 4'h0;
                rx_cnt_q <= 5'd0;
                err_map_q <= {`FIFO_DEPTH{1'b0}};
            end else begin
                if (rx_push_q && !rx_full) begin
                    rx_mem[rx_wp_q] <= rx_word_q;
                    err_map_q[rx_wp_q] <= |rx_word_q[10:8];
                    rx_wp_q <= rx_wp_q + 4'h1;
                end
                if (rx_pop) begin
                    rx_rp_q <= rx_rp_q + 4'h1;
                    if (!(rx_push_q && !rx_full && rx_wp_q == rx_rp_q))
                        err_map_q[rx_rp_q] <= 1'b0;
                end
                rx_cnt_q <= rx_cnt_q + ((rx_push_q && !rx_full) ? 5'd1 : 5'd0)
                    - (rx_pop ? 5'd1 : 5'd0);
            end
            // sticky line flags: set wins over read-clear
            overrun_q <= (rx_push_q && rx_full) | (overrun_q & ~line_condition_rd);
            pe_flag_q <= (rx_pop & rx_head[8]) | (pe_flag_q & ~line_condition_rd);
            fe_flag_q <= (rx_pop & rx_head[9]) | (fe_flag_q & ~line_condition_rd);
            brk_flag_q <= (rx_pop & rx_head[10]) | (brk_flag_q & ~line_condition_rd);
            hs_prev_q <= hs_now;
            delta_q <= hs_evt | (delta_q & {4{~handshake_input_rd}});
        end
    end

    wire tx_empty = (tx_cnt_q == 5'd0);
    wire tsr_empty = tx_empty && tx_st_q == TX_IDLE;
    wire [4:0] trig_lvl = !fifo_en_q ? 5'd1 : (trig_q == 2'b00) ? 5'd1 :
        (trig_q == 2'b01) ? 5'd4 : (trig_q == 2'b10) ? 5'd8 : 5'd14;
    wire [7:0] line_condition_reg = {|err_map_q, tsr_empty, tx_empty, brk_flag_q, fe_flag_q,
        pe_flag_q, overrun_q, rx_cnt_q != 5'd0};
    wire [7:0] handshake_input_reg = {i_dcd, i_ri, i_dsr, i_cts, delta_q};

    // interrupt: data threshold, holding empty, line error, modem change
    assign o_irq = (ier_q[0] && rx_cnt_q >= trig_lvl) || (ier_q[1] && tx_empty) ||
        (ier_q[2] && |line_condition_reg[4:1]) || (ier_q[3] && |delta_q);
    assign o_dtr = handshake_output_reg_q[0];
    assign o_rts = handshake_output_reg_q[1];

    always @(posedge i_clock or negedge rst_b_q) begin
        if (!rst_b_q) begin
            o_rdata <= 8'h00;
        end else if (rd) begin
            case (ofs)
                `OFS_DATA: o_rdata <= divisor_access_select ? div_lo_q : rx_head[7:0];
                `OFS_IER: o_rdata <= divisor_access_select ? div_hi_q : ier_q;
                `OFS_FIFO: o_rdata <= {fifo_en_q, fifo_en_q, 6'h01};
                `OFS_LINE_FMT: o_rdata <= line_format_reg_q;
                `OFS_HS_OUT: o_rdata <= handshake_output_reg_q;
                `OFS_LINE_FLAGS: o_rdata <= line_condition_reg;
                `OFS_HS_IN: o_rdata <= handshake_input_reg;
                default: o_rdata <= scr_q;
            endcase
        end
    end
endmodule

// *** dv/serial_port_checker.sv ***
module serial_port_checker (
    input wire i_clock,
    input wire i_rst_b,
    input wire [9:0] i_addr,
    input wire [9:0] i_base_switch,
    input wire i_rd,
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata,
    input wire o_tx,
    input wire i_cts,
    input wire o_dtr,
    input wire o_rts
);
    timeunit 1ns;
    timeprecision 1ps;
    wire sel = i_addr[9:3] == i_base_switch[9:3];
    wire [2:0] ofs = i_addr[2:0];
    wire wr_at = sel && i_wr;
    wire rd_at = sel && i_rd;
    wire [1:0] hs_wdata = i_wdata[1:0];
    reg div_select_q;
    reg [15:0] low_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    // tracks the divisor select and the length of each low run on the line
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_select_q <= 1'b0;
            low_q <= 16'h0000;
        end else begin
            if (wr_at && ofs == 3'h3) begin
                div_select_q <= i_wdata[7];
            end
            if (o_tx) begin
                low_q <= 16'h0000;
            end else if (low_q != 16'hffff) begin
                low_q <= low_q + 16'h0001;
            end
        end
    end
    property p_hs_out;
        wr_at && ofs == 3'h4 |=> {o_rts, o_dtr} == $past(hs_wdata);
    endproperty
    a_hs_out: assert property (p_hs_out) else $error("handshake out mismatch");
    property p_hs_hold;
        !(wr_at && ofs == 3'h4) |=> $stable(o_rts) && $stable(o_dtr);
    endproperty
    a_hs_hold: assert property (p_hs_hold) else $error("handshake out moved");
    property p_scratch;
        wr_at && ofs == 3'h7 ##1 !i_wr ##1 rd_at && ofs == 3'h7 |=> o_rdata == $past(i_wdata, 3);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch readback");
    property p_div;
        div_select_q && wr_at && ofs == 3'h0 ##1 !i_wr ##1 rd_at && ofs == 3'h0
            |=> o_rdata == $past(i_wdata, 3);
    endproperty
    a_div: assert property (p_div) else $error("divisor readback");
    property p_rd_hold;
        !rd_at |=> $stable(o_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_break;
        wr_at && ofs == 3'h3 && i_wdata[6] |-> ##[1:3] !o_tx;
    endproperty
    a_break: assert property (p_break) else $error("break not driven");
    property p_bit_len;
        $rose(o_tx) |-> low_q >= 16'h0352;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit too short");
    property p_cts;
        rd_at && ofs == 3'h6 && $stable(i_cts) && i_cts == $past(i_cts, 2)
            && i_cts == $past(i_cts, 3) |=> o_rdata[4] == $past(i_cts);
    endproperty
    a_cts: assert property (p_cts) else $error("clear-to-send state");
    c_tx: cover property ($fell(o_tx));
    c_rx_read: cover property (rd_at && ofs == 3'h0);
    c_hs_read: cover property (rd_at && ofs == 3'h6);
endmodule

// *** dv/serial_far_end.sv ***
module serial_far_end (
    input wire o_tx,
    input wire o_dtr,
    input wire o_rts,
    output logic i_rx,
    output wire i_cts,
    output wire i_dsr,
    output logic i_ri,
    output logic i_dcd
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime BIT = 8680.6ns;
    logic [7:0] tx_byte = 8'h00;
    int n_tx = 0;
    // terminal wired straight back: its request follows ours
    assign i_cts = o_rts;
    assign i_dsr = o_dtr;
    initial begin
        i_rx = 1'b1;
        i_ri = 1'b0;
        i_dcd = 1'b0;
    end
    task automatic send(input logic [7:0] v);
        i_rx = 1'b0;
        #BIT;
        for (int k = 0; k < 8; k++) begin
            i_rx = v[k];
            #BIT;
        end
        i_rx = 1'b1;
        #BIT;
    endtask
    task automatic ring;
        i_ri = 1'b1;
        #100ns;
        i_ri = 1'b0;
    endtask
    // samples the eight data bits of an outgoing frame at mid-bit
    always @(negedge o_tx) begin
        #(BIT / 2);
        for (int k = 0; k < 8; k++) begin
            #BIT;
            tx_byte[k] = o_tx;
        end
        #BIT;
        n_tx++;
    end
endmodule

// *** dv/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [9:0] BASE = 10'h2f8;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic [9:0] i_addr = 10'h000;
    logic i_rd = 1'b0;
    logic i_wr = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] d;
    wire [7:0] o_rdata;
    wire o_irq, i_rx, o_tx, i_cts, i_dsr, i_ri, i_dcd, o_dtr, o_rts;
    int miscompares = 0;
    int checks_done = 0;
    fifo_async_serial_port uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_base_switch(BASE), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_irq(o_irq), .i_rx(i_rx), .o_tx(o_tx), .i_cts(i_cts),
        .i_dsr(i_dsr), .i_ri(i_ri), .i_dcd(i_dcd), .o_dtr(o_dtr), .o_rts(o_rts));
    serial_far_end fe (.o_tx(o_tx), .o_dtr(o_dtr), .o_rts(o_rts), .i_rx(i_rx),
        .i_cts(i_cts), .i_dsr(i_dsr), .i_ri(i_ri), .i_dcd(i_dcd));
    initial begin
        forever #5 i_clock = ~i_clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge i_clock) #1;
        i_addr = a;
        i_wdata = v;
        i_wr = 1'b1;
        @(posedge i_clock) #1;
        i_wr = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] v);
        @(posedge i_clock) #1;
        i_addr = a;
        i_rd = 1'b1;
        @(posedge i_clock) #1;
        i_rd = 1'b0;
        v = o_rdata;
    endtask
    task automatic t_regs;
        wr(BASE + 10'h7, 8'ha5);
        rd(BASE + 10'h7, d); chk(d, 8'ha5);
        wr(10'h0ff, 8'h3c);
        rd(BASE + 10'h7, d); chk(d, 8'ha5);
        rd(BASE + 10'h3, d); chk(d, 8'h03);
        wr(BASE + 10'h3, 8'h83);
        rd(BASE, d); chk(d, 8'h0c);
        rd(BASE + 10'h1, d); chk(d, 8'h00);
        wr(BASE, 8'h01);
        rd(BASE, d); chk(d, 8'h01);
        wr(BASE + 10'h3, 8'h03);
        $display("regs done");
    endtask
    task automatic t_hs;
        wr(BASE + 10'h4, 8'h03);
        chk({6'h00, o_rts, o_dtr}, 8'h03);
        repeat (4) @(posedge i_clock);
        rd(BASE + 10'h6, d); chk(d, 8'h33);
        rd(BASE + 10'h6, d); chk(d, 8'h30);
        fe.ring();
        repeat (4) @(posedge i_clock);
        rd(BASE + 10'h6, d); chk(d, 8'h34);
        $display("handshake done");
    endtask
    task automatic t_tx;
        int n;
        n = fe.n_tx;
        rd(BASE + 10'h5, d); chk(d, 8'h60);
        wr(BASE, 8'h55);
        repeat (20) @(posedge i_clock);
        rd(BASE + 10'h5, d); chk(d & 8'h40, 8'h00);
        for (int k = 0; k < 12000 && fe.n_tx == n; k++) @(posedge i_clock);
        chk({7'h00, fe.n_tx != n}, 8'h01);
        chk(fe.tx_byte, 8'h55);
        repeat (1000) @(posedge i_clock);
        rd(BASE + 10'h5, d); chk(d, 8'h60);
        $display("transmit done");
    endtask
    task automatic t_rx;
        fe.send(8'hc3);
        rd(BASE + 10'h5, d); chk(d, 8'h61);
        rd(BASE, d); chk(d, 8'hc3);
        rd(BASE + 10'h5, d); chk(d, 8'h60);
        $display("receive done");
    endtask
    task automatic t_fifo;
        wr(BASE + 10'h2, 8'h41);
        wr(BASE + 10'h1, 8'h01);
        for (logic [7:0] v = 8'h10; v < 8'h14; v++) begin
            chk({7'h00, o_irq}, 8'h00);
            fe.send(v);
        end
        chk({7'h00, o_irq}, 8'h01);
        rd(BASE, d); chk(d, 8'h10);
        chk({7'h00, o_irq}, 8'h00);
        wr(BASE + 10'h2, 8'h43);
        rd(BASE + 10'h5, d); chk(d, 8'h60);
        $display("fifo done");
    endtask
    task automatic t_break;
        wr(BASE + 10'h3, 8'h43);
        repeat (1000) @(posedge i_clock);
        chk({7'h00, o_tx}, 8'h00);
        wr(BASE + 10'h3, 8'h03);
        repeat (4) @(posedge i_clock);
        chk({7'h00, o_tx}, 8'h01);
        $display("break done");
    endtask
    task automatic t_parity;
        wr(BASE + 10'h3, 8'h1b);
        fe.send(8'hc3);
        repeat (1000) @(posedge i_clock);
        rd(BASE + 10'h5, d); chk(d, 8'he1);
        rd(BASE, d); chk(d, 8'hc3);
        rd(BASE + 10'h5, d); chk(d, 8'h64);
        rd(BASE + 10'h5, d); chk(d, 8'h60);
        wr(BASE + 10'h3, 8'h03);
        $display("parity done");
    endtask
    task automatic t_txclr;
        int n;
        n = fe.n_tx;
        wr(BASE, 8'h3a);
        repeat (60) @(posedge i_clock);
        wr(BASE, 8'h5b);
        wr(BASE, 8'h6c);
        wr(BASE + 10'h2, 8'h45);
        rd(BASE + 10'h5, d); chk(d, 8'h20);
        for (int k = 0; k < 12000 && fe.n_tx == n; k++) @(posedge i_clock);
        chk({7'h00, fe.n_tx != n}, 8'h01);
        chk(fe.tx_byte, 8'h3a);
        repeat (1000) @(posedge i_clock);
        rd(BASE + 10'h5, d); chk(d, 8'h60);
        $display("transmit clear done");
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clock);
        #1 i_rst_b = 1'b1;
        repeat (3) @(posedge i_clock);
        t_regs();
        t_hs();
        t_tx();
        t_rx();
        t_fifo();
        t_parity();
        t_txclr();
        t_break();
        close_out();
    end
    initial begin
        #1ms;
        miscompares++;
        close_out();
    end
endmodule
bind fifo_async_serial_port serial_port_checker watch (.i_clock(i_clock),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_base_switch(i_base_switch), .i_rd(i_rd),
    .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_tx(o_tx), .i_cts(i_cts),
    .o_dtr(o_dtr), .o_rts(o_rts));
